// *** design/pressure_sense_control_gate.v ***
`timescale 1ns/10ps
`include "pressure_sense_defs.vh"

module pressure_sense_control_gate (
    input wire mclk,
    input wire rst,
    input wire [1:0] build_option,
    input wire [1:0] units_mode,
    input wire [`VAL_W-1:0] background_value,
    input wire sp_wr_en,
    input wire [`SP_AW-1:0] sp_wr_addr,
    input wire [`VAL_W-1:0] sp_wr_data,
    input wire sch_wr_en,
    input wire [`SCH_AW-1:0] sch_wr_addr,
    input wire [`SP_AW-1:0] sch_wr_sp_index,
    input wire sch_wr_sense_en,
    input wire sch_wr_falling,
    input wire [`VAL_W-1:0] sch_wr_threshold,
    input wire grant_func_interlock,
    input wire grant_source_local,
    input wire request_func_interlock,
    input wire squeeze_start,
    input wire [`SCH_AW-1:0] squeeze_schedule,
    input wire squeeze_done,
    input wire sequence_end,
    input wire adc_valid,
    input wire [`CODE_W-1:0] adc_code,
    input wire weld_grant_input,
    output reg [`CODE_W-1:0] valve_code_reg,
    output reg valve_drive_reg,
    output reg [`VAL_W-1:0] meas_value_reg,
    output reg meas_valid_reg,
    output reg trigger_seen_reg,
    output reg weld_request_output,
    output reg weld_enable_reg,
    output reg [2:0] state_reg
);
    // Setpoint store and per-schedule settings
    reg [`VAL_W-1:0] sp_mem [0:`SP_COUNT-1];
    reg [`SP_AW-1:0] sch_index_mem [0:`SCH_COUNT-1];
    reg sch_sense_mem [0:`SCH_COUNT-1];
    reg sch_falling_mem [0:`SCH_COUNT-1];
    reg [`VAL_W-1:0] sch_thresh_mem [0:`SCH_COUNT-1];

    reg [`SCH_AW-1:0] sched_reg;
    reg [`SCH_AW-1:0] sched_next;
    reg [2:0] state_next;
    reg [`VAL_W-1:0] unit_lo;
    reg [`VAL_W-1:0] unit_span;
    reg [`VAL_W-1:0] target;
    reg [`SP_AW-1:0] active_index;
    wire [`VAL_W-1:0] code_wide;
    wire [`VAL_W-1:0] meas_conv;
    wire can_control;
    wire can_sense;
    wire interlock_on;
    wire sense_gate;
    wire [`VAL_W-1:0] active_thresh;
    wire active_falling;
    wire rise_hit;
    wire fall_hit;
    wire trig_hit;

    // Build option decode
    // control-capable options
    assign can_control = (build_option == `OPT_CONTROL) ||
                         (build_option == `OPT_BOTH);
    assign can_sense = (build_option == `OPT_SENSE) ||
                       (build_option == `OPT_BOTH);

    assign interlock_on = grant_func_interlock && grant_source_local &&
                          request_func_interlock;

    // Settings of the schedule now executing
    // per-schedule edge selection
    assign active_falling = sch_falling_mem[sched_reg];
    assign active_thresh = sch_thresh_mem[sched_reg];
    assign sense_gate = can_sense && sch_sense_mem[sched_reg];

    // Table writes; setpoint addresses past the store are dropped
    // hundred setpoint slots
    always @(posedge mclk) begin
        if (sp_wr_en && (sp_wr_addr < `SP_COUNT))
            sp_mem[sp_wr_addr] <= sp_wr_data;
        if (sch_wr_en) begin
            sch_index_mem[sch_wr_addr] <= sch_wr_sp_index;
            sch_sense_mem[sch_wr_addr] <= sch_wr_sense_en;
            sch_falling_mem[sch_wr_addr] <= sch_wr_falling;
            sch_thresh_mem[sch_wr_addr] <= sch_wr_threshold;
        end
    end

    // Unit range from the single global mode
    // global units mode
    always @* begin
        unit_lo = `MA_LO;
        unit_span = `MA_SPAN;
        case (units_mode)
            `MODE_MA: begin
                unit_lo = `MA_LO;
                unit_span = `MA_SPAN;
            end
            `MODE_CAL_LB: begin
                unit_lo = `LB_LO;
                unit_span = `LB_SPAN;
            end
            `MODE_PSI: begin
                unit_lo = `PSI_LO;
                unit_span = `PSI_SPAN;
            end
            `MODE_LB: begin
                unit_lo = `LB_LO;
                unit_span = `LB_SPAN;
            end
            default: begin
                unit_lo = `MA_LO;
                unit_span = `MA_SPAN;
            end
        endcase
    end

    // Valve target: background while idle, schedule setpoint otherwise, range low end if its index is past the store
    always @* begin
        active_index = sch_index_mem[sched_reg];
        target = background_value;
        if (state_reg == `ST_IDLE)
            target = background_value;
        else if (active_index < `SP_COUNT)
            target = sp_mem[active_index];
        else
            target = unit_lo;
    end

    // units to valve code, 4..20 mA span
    linear_scale to_valve (
        .value(target),
        .in_lo(unit_lo),
        .in_span(unit_span),
        .out_lo(`CODE_4MA),
        .out_span(`CODE_SPAN),
        .result(code_wide)
    );

    linear_scale from_sensor (
        .value({4'h0, adc_code}),
        .in_lo(`CODE_4MA),
        .in_span(`CODE_SPAN),
        .out_lo(unit_lo),
        .out_span(unit_span),
        .result(meas_conv)
    );

    // Edge crossings between the held and the fresh sample
    // crossing definition
    assign rise_hit = (meas_value_reg < active_thresh) &&
                      (meas_conv >= active_thresh);
    assign fall_hit = (meas_value_reg >= active_thresh) &&
                      (meas_conv < active_thresh);
    assign trig_hit = adc_valid && can_sense &&
                      (active_falling ? fall_hit : rise_hit);

    // Measurement path; control-only builds report nothing
    // sense and report
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            meas_value_reg <= 16'h0000;
            meas_valid_reg <= 1'b0;
            trigger_seen_reg <= 1'b0;
        end else begin
            trigger_seen_reg <= trig_hit;
            if (!can_sense) begin
                meas_value_reg <= 16'h0000;
                meas_valid_reg <= 1'b0;
            end else if (adc_valid) begin
                meas_value_reg <= meas_conv;
                meas_valid_reg <= 1'b1;
            end
        end
    end

    // Sequence gate state machine
    always @* begin
        state_next = state_reg;
        sched_next = sched_reg;
        case (state_reg)
            `ST_IDLE: begin
                state_next = `ST_IDLE;
            end
            `ST_SQZ: begin
                if (squeeze_done) begin
                    if (sense_gate)
                        state_next = `ST_TRIG;
                    else if (interlock_on)
                        state_next = `ST_REQ;
                    else
                        state_next = `ST_GO;
                end
            end
            `ST_TRIG: begin
                if (trig_hit)
                    state_next = interlock_on ? `ST_REQ : `ST_GO;
            end
            `ST_REQ: begin
                if (weld_grant_input)
                    state_next = `ST_GO;
            end
            `ST_GO: begin
                state_next = `ST_GO;
            end
            default: begin
                state_next = `ST_IDLE;
            end
        endcase
        // A new squeeze restarts from any state; chained schedules land here
        // chained schedule update
        if (squeeze_start) begin
            state_next = `ST_SQZ;
            sched_next = squeeze_schedule;
        end else if (sequence_end) begin
            state_next = `ST_IDLE;
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= `ST_IDLE;
            sched_reg <= 6'h00;
        end else begin
            state_reg <= state_next;
            sched_reg <= sched_next;
        end
    end

    // Outputs registered from the next state so they line up with it
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            weld_request_output <= 1'b0;
            weld_enable_reg <= 1'b0;
        end else begin
            weld_request_output <= (state_next == `ST_REQ);
            weld_enable_reg <= (state_next == `ST_GO);
        end
    end

    // Valve command; one cycle after the schedule is latched at squeeze
    // start the new setpoint reaches the pins
    // setpoint at squeeze start
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            valve_code_reg <= 12'h000;
            valve_drive_reg <= 1'b0;
        end else if (can_control) begin
            valve_code_reg <= code_wide[`CODE_W-1:0];
            valve_drive_reg <= 1'b1;
        end else begin
            valve_code_reg <= 12'h000;
            valve_drive_reg <= 1'b0;
        end
    end
endmodule

// *** common/pressure_sense_defs.vh ***
// Behaviour
// - Control-only build drives per-schedule setpoint, never senses or reports pressure.
// - Sense-only build measures and reports, drives no valve, runs valveless.
// - Combined build drives per-schedule setpoint and reports measured value.
// - Sensing builds hold sequence after squeeze until selected edge trigger.
// - Rising or falling selection stored per schedule, active schedule's used.
// - Milliamp units cover 4.00 to 20.00 mA.
// - Calibrated force covers 0.0 to 7850.0 lb in 0.5 lb steps.
// - Pressure units cover 0 to 100 PSI.
// - Uncalibrated force uses the same 0.0 to 7850.0 lb range.
// - Transducer 4.00 to 20.00 mA reads as 0 to 100 PSI.
// - Valve command 4.00 to 20.00 mA means 0 to 100 PSI.
// - One hundred setpoints stored, any selectable by a schedule.
// - Schedule setpoint reaches valve at start of its squeeze.
// - Chained schedules each update the valve setpoint in turn.
// - Falling trigger allowed at near-zero threshold.
// - Interlock: raise weld request after squeeze, wait for grant, then weld.
// - Interlock needs grant input local interlock and request output interlock.
// - Units mode is one global setting for all schedules.
// - With sensing on, weld withheld until schedule trigger level reached.
// - While idle, valve driven to background pressure or force.
`ifndef PRESSURE_SENSE_DEFS_VH
`define PRESSURE_SENSE_DEFS_VH

// Build options
`define OPT_CONTROL 2'h0
`define OPT_SENSE 2'h1
`define OPT_BOTH 2'h2

// Global units modes
`define MODE_MA 2'h0
`define MODE_CAL_LB 2'h1
`define MODE_PSI 2'h2
`define MODE_LB 2'h3

// Unit ranges: mA in hundredths, force in half pounds, PSI whole
`define MA_LO 16'h0190
`define MA_SPAN 16'h0640
`define LB_LO 16'h0000
`define LB_SPAN 16'h3D54
`define PSI_LO 16'h0000
`define PSI_SPAN 16'h0064

// 12-bit converters at 0..20 mA full scale: 4 mA and span to 20 mA
`define CODE_4MA 16'h0333
`define CODE_SPAN 16'h0CCC

// Tables
`define SP_COUNT 7'h64
`define SP_AW 7
`define SCH_COUNT 64
`define SCH_AW 6
`define VAL_W 16
`define CODE_W 12

// Sequence states
`define ST_IDLE 3'h0
`define ST_SQZ 3'h1
`define ST_TRIG 3'h2
`define ST_REQ 3'h3
`define ST_GO 3'h4

`endif

// *** design/linear_scale.v ***
`timescale 1ns/10ps
`include "pressure_sense_defs.vh"

// Maps value from [in_lo, in_lo+in_span] onto [out_lo, out_lo+out_span]
module linear_scale (
    input wire [`VAL_W-1:0] value,
    input wire [`VAL_W-1:0] in_lo,
    input wire [`VAL_W-1:0] in_span,
    input wire [`VAL_W-1:0] out_lo,
    input wire [`VAL_W-1:0] out_span,
    output reg [`VAL_W-1:0] result
);
    reg [`VAL_W-1:0] offset;
    reg [31:0] product;
    reg [31:0] quotient;

    // Clamp into range first so out-of-range readings saturate
    always @* begin
        offset = 16'h0000;
        product = 32'h00000000;
        quotient = 32'h00000000;
        if (value > in_lo)
            offset = value - in_lo;
        if (offset > in_span)
            offset = in_span;
        product = {16'h0000, offset} * {16'h0000, out_span};
        if (in_span != 16'h0000)
            quotient = product / {16'h0000, in_span};
        result = out_lo + quotient[`VAL_W-1:0];
    end
endmodule

// *** tb/psc_chk.sv ***
`timescale 1ns/10ps
`include "pressure_sense_defs.vh"
module psc_chk (
    input wire mclk,
    input wire rst,
    input wire [1:0] build_option,
    input wire squeeze_start,
    input wire squeeze_done,
    input wire sequence_end,
    input wire adc_valid,
    input wire weld_grant_input,
    input wire valve_drive_reg,
    input wire trigger_seen_reg,
    input wire weld_request_output,
    input wire weld_enable_reg,
    input wire [2:0] state_reg
);
// No restart or end pending, so the state may only move on its own cause
wire calm = !squeeze_start && !sequence_end;
default clocking @(posedge mclk); endclocking
default disable iff (rst);
AST_START: assert property (squeeze_start |=> state_reg == `ST_SQZ)
    else $error("squeeze not entered");
AST_SQZ_HOLD: assert property (state_reg == `ST_SQZ && !squeeze_done && calm
    |=> state_reg == `ST_SQZ) else $error("squeeze left early");
AST_TRIG_WAIT: assert property (state_reg == `ST_TRIG && !adc_valid && calm
    |=> state_reg == `ST_TRIG) else $error("trigger wait left");
AST_TRIG_CAUSE: assert property (trigger_seen_reg |-> $past(adc_valid) &&
    $past(state_reg) == `ST_TRIG ##1 !trigger_seen_reg) else $error("bad trigger");
AST_REQ_WAIT: assert property (state_reg == `ST_REQ && !weld_grant_input && calm
    |=> state_reg == `ST_REQ && weld_request_output) else $error("request lost");
AST_GRANT: assert property (state_reg == `ST_REQ && weld_grant_input && calm
    |=> state_reg == `ST_GO && weld_enable_reg && !weld_request_output)
    else $error("grant not taken");
AST_END: assert property (sequence_end && !squeeze_start
    |=> state_reg == `ST_IDLE && !weld_enable_reg) else $error("no idle");
AST_NO_VALVE: assert property ((build_option == `OPT_SENSE) [*2]
    |-> !valve_drive_reg) else $error("valve driven");
endmodule
bind pressure_sense_control_gate psc_chk chk (.mclk(mclk), .rst(rst),
    .build_option(build_option), .squeeze_start(squeeze_start),
    .squeeze_done(squeeze_done), .sequence_end(sequence_end),
    .adc_valid(adc_valid), .weld_grant_input(weld_grant_input),
    .valve_drive_reg(valve_drive_reg), .trigger_seen_reg(trigger_seen_reg),
    .weld_request_output(weld_request_output),
    .weld_enable_reg(weld_enable_reg), .state_reg(state_reg));

// *** tb/line_partner.sv ***
`timescale 1ns/10ps
module line_partner (
    input wire mclk,
    input wire rst,
    input wire [11:0] line_code,
    input wire [3:0] grant_lag,
    input wire weld_request_output,
    output reg adc_valid,
    output reg [11:0] adc_code,
    output reg weld_grant_input
);
reg [1:0] phase_reg;
reg [3:0] wait_reg;
// Sensor converts every fourth cycle; code scrambles between samples
// grant after a lag, dropped with the request
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        phase_reg <= 2'h0;
        adc_valid <= 1'h0;
        adc_code <= 12'h000;
        wait_reg <= 4'h0;
        weld_grant_input <= 1'h0;
    end else begin
        phase_reg <= phase_reg + 2'h1;
        adc_valid <= phase_reg == 2'h3;
        adc_code <= phase_reg == 2'h3 ? line_code : ~adc_code;
        wait_reg <= weld_request_output ? wait_reg + 4'h1 : 4'h0;
        weld_grant_input <= weld_request_output && wait_reg >= grant_lag;
    end
end
endmodule

// *** tb/pressure_sense_control_gate_bench.sv ***
`timescale 1ns/10ps
`include "pressure_sense_defs.vh"
module pressure_sense_control_gate_bench;
reg mclk, rst, sp_we, sch_we, sns, fal, gfi, gsl, rfi, sq_go, sq_dn, sq_end;
reg [1:0] bo, um;
reg [6:0] sp_a, sch_sp;
reg [5:0] sch_a, sq_s;
reg [15:0] bg, sp_d, thr;
reg [11:0] line;
reg [3:0] lag;
reg [16:0] rnd;
wire [11:0] adc, vcode;
wire adc_v, grant, vdrive, mvalid, trig, req, wen;
wire [15:0] meas;
wire [2:0] st;
integer n_fail = 0, n_compared = 0, cyc = 0, m, k, pc, pm, pb, pv;
integer sp_t [0:127];
integer s_sp [0:63], s_sn [0:63], s_fl [0:63];
pressure_sense_control_gate uut (.mclk(mclk), .rst(rst), .build_option(bo),
    .units_mode(um), .background_value(bg), .sp_wr_en(sp_we),
    .sp_wr_addr(sp_a), .sp_wr_data(sp_d), .sch_wr_en(sch_we),
    .sch_wr_addr(sch_a), .sch_wr_sp_index(sch_sp), .sch_wr_sense_en(sns),
    .sch_wr_falling(fal), .sch_wr_threshold(thr),
    .grant_func_interlock(gfi), .grant_source_local(gsl),
    .request_func_interlock(rfi), .squeeze_start(sq_go),
    .squeeze_schedule(sq_s), .squeeze_done(sq_dn), .sequence_end(sq_end),
    .adc_valid(adc_v), .adc_code(adc), .weld_grant_input(grant),
    .valve_code_reg(vcode), .valve_drive_reg(vdrive), .meas_value_reg(meas),
    .meas_valid_reg(mvalid), .trigger_seen_reg(trig),
    .weld_request_output(req), .weld_enable_reg(wen), .state_reg(st));
line_partner far (.mclk(mclk), .rst(rst), .line_code(line), .grant_lag(lag),
    .weld_request_output(req), .adc_valid(adc_v), .adc_code(adc),
    .weld_grant_input(grant));
// Free-running clock
initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
end
function integer lo(input integer md);
    lo = md == 0 ? `MA_LO : 0;
endfunction
function integer span(input integer md);
    span = md == 0 ? `MA_SPAN : md == 2 ? `PSI_SPAN : `LB_SPAN;
endfunction
// Maximal 17-bit shift register, taps 17 and 14
function [16:0] lfsr_next(input [16:0] v);
    lfsr_next = {v[15:0], v[16] ^ v[13]};
endfunction
// Units to converter code, clamped to the mode's range
function integer to_code(input integer u, input integer md);
    integer v;
    begin
        v = u - lo(md);
        v = v < 0 ? 0 : v > span(md) ? span(md) : v;
        to_code = `CODE_4MA + v * `CODE_SPAN / span(md);
    end
endfunction
function integer to_units(input integer c, input integer md);
    integer v;
    begin
        v = c - `CODE_4MA;
        to_units = lo(md) + (v < 0 ? 0 : v) * span(md) / `CODE_SPAN;
    end
endfunction
task cmp(input [15:0] got, input integer exp);
    begin
        n_compared = n_compared + 1;
        if (got !== exp[15:0]) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0t got %h want %h", $time, got, exp[15:0]);
        end
    end
endtask
task tick;
    @(negedge mclk);
endtask
task wr_sp(input integer a, input integer d);
    begin
        sp_a = a[6:0];
        sp_d = d[15:0];
        sp_we = 1'h1;
        tick;
        sp_we = 1'h0;
        if (a < 100) sp_t[a] = d;
        tick;
    end
endtask
task wr_sch(input integer a, input integer i, input integer n, input integer f,
    input integer th);
    begin
        {sch_a, sch_sp, sns, fal, thr} = {a[5:0], i[6:0], n[0], f[0], th[15:0]};
        sch_we = 1'h1;
        tick;
        sch_we = 1'h0;
        {s_sp[a], s_sn[a], s_fl[a]} = {i, n, f};
        tick;
    end
endtask
// One schedule; chained when fin is zero, the next start restarts it
task run(input integer s, input integer fin);
    integer e, ilk, i;
    begin
        ilk = gfi && gsl && rfi;
        line = s_fl[s] ? 12'hFFF : 12'h333;
        sq_s = s[5:0];
        sq_go = 1'h1;
        tick;
        sq_go = 1'h0;
        cmp(st, 1);
        tick;
        e = s_sp[s] < 100 ? sp_t[s_sp[s]] : lo(um);
        cmp(vcode, bo == 1 ? 0 : to_code(e, um));
        cmp(vdrive, bo != 1);
        repeat (5) tick;
        sq_dn = 1'h1;
        tick;
        sq_dn = 1'h0;
        e = s_sn[s] && bo != 0 ? 2 : ilk ? 3 : 4;
        cmp(st, e);
        cmp(req, e == 3);
        if (e == 2) begin
            repeat (9) tick;
            cmp(st, 2);
            line = s_fl[s] ? 12'h333 : 12'hFFF;
            for (i = 0; i < 12 && st == 2; i = i + 1) tick;
            cmp(trig, 1);
            cmp(st, ilk ? 3 : 4);
        end
        for (i = 0; i < 20 && st == 3; i = i + 1) tick;
        cmp(wen, 1);
        if (fin) begin
            sq_end = 1'h1;
            tick;
            sq_end = 1'h0;
            tick;
            cmp(vcode, bo == 1 ? 0 : to_code(bg, um));
        end
    end
endtask
// Every sample is checked one settle delay after the edge that took it
always @(posedge mclk) begin
    pv = adc_v;
    pc = adc;
    pm = um;
    pb = bo;
    #1;
    if (!rst && pv) begin
        cmp(meas, pb == 0 ? 0 : to_units(pc, pm));
        cmp(mvalid, pb != 0);
    end
end
// Hang guard
always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
        n_fail = n_fail + 1;
        test_done;
    end
end
task test_done;
    begin
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    end
endtask
// Every units mode against all three builds, chained schedules
initial begin
    {rst, sp_we, sch_we, sns, fal, gfi, gsl, rfi, sq_go, sq_dn, sq_end} = 11'h400;
    {bo, um, sp_a, sch_sp, sch_a, sq_s, bg, sp_d, thr, lag} = 0;
    line = 12'h333;
    rnd = 17'h10F4B;
    repeat (6) @(posedge mclk);
    tick;
    cmp(st, 0);
    rst = 1'h0;
    for (m = 0; m < 4; m = m + 1) begin
        um = m[1:0];
        rnd = lfsr_next(rnd);
        bg = lo(m) + rnd % (span(m) + 1);
        // Even modes map only part of the interlock, so it must stay off
        {gfi, gsl, rfi, lag} = {1'h1, m[0] | m[1], m[0] | !m[1], rnd[3:0]};
        wr_sp(0, lo(m) + rnd[16:1] % (span(m) + 1));
        wr_sp(99, lo(m) + span(m));
        wr_sp(100, 0);
        wr_sch(0, 0, 1, 0, lo(m) + span(m) / 2);
        wr_sch(1, 99, 1, 1, lo(m) + 1);
        wr_sch(2, 100, 0, 0, 0);
        for (k = 0; k < 3; k = k + 1) begin
            bo = k == 0 ? 2'h2 : k[1:0] - 2'h1;
            run(0, 0);
            run(1, 0);
            run(2, 1);
        end
    end
    test_done;
end
endmodule
